/* File: common/ptc_pkg.sv */
// constants for the timing clock control and status registers
package ptc_pkg;
  localparam int          DATA_W            = 16;
  localparam int          ADDR_W            = 5;
  localparam int          TIME_W            = 64;
  localparam int          WORDS             = 4;

  // register offsets (management address space)
  localparam logic [4:0]  PAGE_SEL_ADDR     = 5'h13;
  localparam logic [4:0]  CTL_ADDR          = 5'h14;
  localparam logic [4:0]  TDR_ADDR          = 5'h15;
  localparam logic [4:0]  STS_ADDR          = 5'h16;
  localparam logic [2:0]  PAGE_TIMING       = 3'h4;
  localparam logic [2:0]  PAGE_RESET        = 3'h0;

  // control register bit positions
  localparam int          CTL_CLK_RESET     = 0;
  localparam int          CTL_CLK_HALT      = 1;
  localparam int          CTL_CLK_RUN       = 2;
  localparam int          CTL_CLK_STEP      = 3;
  localparam int          CTL_CLK_LOAD      = 4;
  localparam int          CTL_CLK_SAMPLE    = 5;
  localparam int          CTL_TRIG_LOAD     = 6;
  localparam int          CTL_TRIG_READ     = 7;

  // status register bit positions
  localparam int          STS_TX_RDY        = 11;
  localparam int          STS_RX_RDY        = 10;
  localparam int          STS_TRIGGER_COMPLETED_FLAG     = 9;
  localparam int          STS_EVENT_RDY     = 8;
  localparam int          STS_TX_IE         = 3;
  localparam int          STS_RX_IE         = 2;
  localparam int          STS_TRIGGER_IRQ_EN       = 1;
  localparam int          STS_EVENT_STAMP_IRQ_EN      = 0;

  // reset values
  localparam logic [15:0] WORD_RESET        = 16'h0000;
  localparam logic [3:0]  IE_RESET          = 4'h0;
  localparam logic [63:0] TIME_RESET        = 64'h0000_0000_0000_0000;

  // time base
  localparam int          CLK_PERIOD_NS     = 10;
  localparam logic [31:0] TICK_NS           = 32'(CLK_PERIOD_NS);
  localparam logic [31:0] NS_PER_SEC        = 32'h3B9A_CA00;

  typedef enum logic [1:0] {
    PTC_SRC_NONE  = 2'b00,
    PTC_SRC_CLOCK = 2'b01,
    PTC_SRC_TRIG  = 2'b10
  } ptc_src_e;

  typedef enum logic [1:0] {
    PTC_DST_CLOCK = 2'b00,
    PTC_DST_TRIG  = 2'b01
  } ptc_dst_e;
endpackage : ptc_pkg

/* File: common/ptc_time_if.sv */
// command and state signals between the register logic and the time counter
`timescale 1ns/100ps
interface ptc_time_if;
  logic        clr;
  logic        load;
  logic        step;
  logic        run_set;
  logic        halt;
  logic [63:0] value;
  logic [63:0] now;
  logic        running;

  modport ctl (output clr, output load, output step, output run_set, output halt, output value,
               input now, input running);
  modport cnt (input clr, input load, input step, input run_set, input halt, input value,
               output now, output running);
endinterface : ptc_time_if

/* File: hdl/ptc_word_ptr.sv */
// saturating word index for multi-word transfers through the time data port
`timescale 1ns/100ps
module ptc_word_ptr #(
  parameter int unsigned COUNT = 4
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       clr,
  input  wire logic       adv,
  output logic      [2:0] idx,
  output logic            done
);
  logic [2:0] idx_r;

  always_ff @(posedge mclk) begin
    if (rst || clr) begin
      idx_r <= 3'h0;
    end else if (adv && !done) begin
      idx_r <= idx_r + 3'h1;
    end
  end

  assign idx  = idx_r;
  assign done = (idx_r >= 3'(COUNT));
endmodule : ptc_word_ptr

/* File: hdl/ptc_time_counter.sv */
// free running seconds and nanoseconds counter with load, step and halt
`timescale 1ns/100ps
module ptc_time_counter (
  input  wire logic mclk,
  input  wire logic rst,
  ptc_time_if.cnt   tif
);
  logic [31:0] sec_r;
  logic [31:0] ns_r;
  logic        run_r;
  logic [32:0] tick_sum;
  logic [32:0] step_sum;

  assign tick_sum = {1'b0, ns_r} + {1'b0, ptc_pkg::TICK_NS};
  assign step_sum = {1'b0, ns_r} + {1'b0, tif.value[31:0]};

  // run state follows the run and halt commands
  always_ff @(posedge mclk) begin
    if (rst || tif.clr) begin
      run_r <= 1'b0;
    end else if (tif.halt) begin
      run_r <= 1'b0;
    end else if (tif.run_set) begin
      run_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || tif.clr) begin
      sec_r <= ptc_pkg::TIME_RESET[63:32];
      ns_r  <= ptc_pkg::TIME_RESET[31:0];
    end else if (tif.load) begin
      sec_r <= tif.value[63:32];
      ns_r  <= tif.value[31:0];
    end else if (tif.step) begin
      if (step_sum >= {1'b0, ptc_pkg::NS_PER_SEC}) begin
        ns_r  <= 32'(step_sum - {1'b0, ptc_pkg::NS_PER_SEC});
        sec_r <= sec_r + tif.value[63:32] + 32'h1;
      end else begin
        ns_r  <= step_sum[31:0];
        sec_r <= sec_r + tif.value[63:32];
      end
    end else if (run_r) begin
      if (tick_sum >= {1'b0, ptc_pkg::NS_PER_SEC}) begin
        ns_r  <= 32'(tick_sum - {1'b0, ptc_pkg::NS_PER_SEC});
        sec_r <= sec_r + 32'h1;
      end else begin
        ns_r  <= tick_sum[31:0];
      end
    end
  end

  assign tif.now     = {sec_r, ns_r};
  assign tif.running = run_r;
endmodule : ptc_time_counter

/* File: hdl/ptc_clock_regs.sv */
// control, time data and status registers of the timing clock
`timescale 1ns/100ps
// Contract
// - load command copies the written data words into the time clock; self-clearing.
// - step command adds the written data words to the running clock; self-clearing.
// - writing one to run starts the clock; reads show running; zero does nothing.
// - writing one to halt stops the clock; zero does nothing; reads zero.
// - clock reset clears clock, its logic and timing registers except output/source config.
// - clock reset stays set until software writes zero; logic held reset meanwhile.
// - successive data port reads return consecutive words of selected clock or trigger value.
// - reads past the last available word return zero.
// - successive data port writes store consecutive words for clock or trigger.
// - transmit stamp ready shows while an outbound stamp waits.
// - receive stamp ready shows while an inbound stamp waits.
// - trigger done sets on notified trigger fire, clears on status read.
// - event stamp ready shows while an event stamp is pending.
// - transmit and receive interrupt enables are read-write, reset to zero.
// - trigger and event interrupt enables are read-write, reset to zero.
// - status bits fifteen to twelve and seven to four ignore writes, read zero.
// - sample command captures the clock for word-by-word reading.
module ptc_clock_regs (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        tx_stamp_pending,
  input  wire logic        rx_stamp_pending,
  input  wire logic        event_stamp_pending,
  input  wire logic        trigger_fired,
  input  wire logic        trigger_notify,
  input  wire logic [63:0] trigger_info,
  output logic             trigger_word_valid,
  output logic      [1:0]  trigger_word_idx,
  output logic      [15:0] trigger_word,
  output logic             timing_reset_active,
  output logic             clock_running,
  output logic      [63:0] clock_time,
  output logic             irq
);
  ptc_time_if tif ();

  logic [2:0]  register_page_select_r;
  logic        clock_reset_bit_r;
  logic        timing_rst;
  logic        page_ok;
  logic        wr_ctl;
  logic        wr_tdr;
  logic        wr_sts;
  logic        rd_tdr;
  logic        rd_sts;
  logic        cmd_ok;

  ptc_pkg::ptc_src_e rd_src_r;
  ptc_pkg::ptc_dst_e wr_dst_r;

  logic [15:0] wr_words_r [ptc_pkg::WORDS];
  logic [63:0] sample_r;
  logic [63:0] rd_value;
  logic [2:0]  rd_idx;
  logic        rd_done;
  logic [2:0]  wr_idx;
  logic        wr_done;
  logic        rd_ptr_clr;
  logic        wr_ptr_clr;

  logic        trigger_completed_flag_r;
  logic        tx_stamp_ready;
  logic        rx_stamp_ready;
  logic        event_stamp_ready;
  logic [3:0]  irq_en_r;
  logic [3:0]  flags;

  logic [15:0] rdata_nxt;
  logic [15:0] reg_rdata_r;
  logic        reg_rvalid_r;
  logic        irq_r;
  logic        trig_valid_r;
  logic [1:0]  trig_idx_r;
  logic [15:0] trig_word_r;
  logic        clock_running_r;
  logic [63:0] clock_time_r;
  logic        timing_reset_r;

  // address decode
  assign page_ok = (register_page_select_r == ptc_pkg::PAGE_TIMING);
  assign wr_ctl  = reg_wr && page_ok && (reg_addr == ptc_pkg::CTL_ADDR);
  assign wr_tdr  = reg_wr && page_ok && (reg_addr == ptc_pkg::TDR_ADDR);
  assign wr_sts  = reg_wr && page_ok && (reg_addr == ptc_pkg::STS_ADDR);
  assign rd_tdr  = reg_rd && page_ok && (reg_addr == ptc_pkg::TDR_ADDR);
  assign rd_sts  = reg_rd && page_ok && (reg_addr == ptc_pkg::STS_ADDR);

  // command bits act only when the clock is already out of reset and the same write leaves it so
  assign cmd_ok = wr_ctl && !reg_wdata[ptc_pkg::CTL_CLK_RESET] && !clock_reset_bit_r;

  // page register lives outside the timing block and survives clock reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      register_page_select_r <= ptc_pkg::PAGE_RESET;
    end else if (reg_wr && (reg_addr == ptc_pkg::PAGE_SEL_ADDR)) begin
      register_page_select_r <= reg_wdata[2:0];
    end
  end

  // reset bit held until written zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      clock_reset_bit_r <= 1'b0;
    end else if (wr_ctl) begin
      clock_reset_bit_r <= reg_wdata[ptc_pkg::CTL_CLK_RESET];
    end
  end

  assign timing_rst = rst || clock_reset_bit_r;

  assign tif.load    = cmd_ok && reg_wdata[ptc_pkg::CTL_CLK_LOAD];
  assign tif.step    = cmd_ok && reg_wdata[ptc_pkg::CTL_CLK_STEP];
  assign tif.run_set = cmd_ok && reg_wdata[ptc_pkg::CTL_CLK_RUN];
  assign tif.halt    = cmd_ok && reg_wdata[ptc_pkg::CTL_CLK_HALT];
  assign tif.clr     = clock_reset_bit_r;
  assign tif.value   = {wr_words_r[3], wr_words_r[2], wr_words_r[1], wr_words_r[0]};

  ptc_time_counter u_counter (
    .mclk (mclk),
    .rst  (rst),
    .tif  (tif)
  );

  // read source selection
  always_ff @(posedge mclk) begin
    if (timing_rst) begin
      rd_src_r <= ptc_pkg::PTC_SRC_NONE;
    end else if (cmd_ok && reg_wdata[ptc_pkg::CTL_CLK_SAMPLE]) begin
      rd_src_r <= ptc_pkg::PTC_SRC_CLOCK;
    end else if (cmd_ok && reg_wdata[ptc_pkg::CTL_TRIG_READ]) begin
      rd_src_r <= ptc_pkg::PTC_SRC_TRIG;
    end
  end

  always_ff @(posedge mclk) begin
    if (timing_rst) begin
      sample_r <= ptc_pkg::TIME_RESET;
    end else if (cmd_ok && reg_wdata[ptc_pkg::CTL_CLK_SAMPLE]) begin
      sample_r <= tif.now;
    end
  end

  assign rd_ptr_clr = cmd_ok && (reg_wdata[ptc_pkg::CTL_CLK_SAMPLE] || reg_wdata[ptc_pkg::CTL_TRIG_READ]);

  ptc_word_ptr #(
    .COUNT (ptc_pkg::WORDS)
  ) u_rd_ptr (
    .mclk (mclk),
    .rst  (timing_rst),
    .clr  (rd_ptr_clr),
    .adv  (rd_tdr),
    .idx  (rd_idx),
    .done (rd_done)
  );

  // write destination: trigger after a trigger load, clock otherwise
  always_ff @(posedge mclk) begin
    if (timing_rst) begin
      wr_dst_r <= ptc_pkg::PTC_DST_CLOCK;
    end else if (cmd_ok && reg_wdata[ptc_pkg::CTL_TRIG_LOAD]) begin
      wr_dst_r <= ptc_pkg::PTC_DST_TRIG;
    end else if (wr_tdr && (wr_dst_r == ptc_pkg::PTC_DST_TRIG) && (wr_idx == 3'(ptc_pkg::WORDS - 1))) begin
      wr_dst_r <= ptc_pkg::PTC_DST_CLOCK;
    end else if (cmd_ok && (reg_wdata[ptc_pkg::CTL_CLK_LOAD] || reg_wdata[ptc_pkg::CTL_CLK_STEP])) begin
      wr_dst_r <= ptc_pkg::PTC_DST_CLOCK;
    end
  end

  // word sequence restarts after each consuming command
  assign wr_ptr_clr = cmd_ok && (reg_wdata[ptc_pkg::CTL_CLK_LOAD] || reg_wdata[ptc_pkg::CTL_CLK_STEP]
                                 || reg_wdata[ptc_pkg::CTL_TRIG_LOAD]);

  ptc_word_ptr #(
    .COUNT (ptc_pkg::WORDS)
  ) u_wr_ptr (
    .mclk (mclk),
    .rst  (timing_rst),
    .clr  (wr_ptr_clr),
    .adv  (wr_tdr),
    .idx  (wr_idx),
    .done (wr_done)
  );

  // consecutive writes fill consecutive clock words
  always_ff @(posedge mclk) begin
    if (timing_rst) begin
      for (int i = 0; i < ptc_pkg::WORDS; i++) begin
        wr_words_r[i] <= ptc_pkg::WORD_RESET;
      end
    end else if (wr_tdr && !wr_done && (wr_dst_r == ptc_pkg::PTC_DST_CLOCK)) begin
      wr_words_r[wr_idx[1:0]] <= reg_wdata;
    end
  end

  // trigger words passed out one by one
  always_ff @(posedge mclk) begin
    if (timing_rst) begin
      trig_valid_r <= 1'b0;
      trig_idx_r   <= 2'h0;
      trig_word_r  <= ptc_pkg::WORD_RESET;
    end else begin
      trig_valid_r <= wr_tdr && !wr_done && (wr_dst_r == ptc_pkg::PTC_DST_TRIG);
      if (wr_tdr && !wr_done && (wr_dst_r == ptc_pkg::PTC_DST_TRIG)) begin
        trig_idx_r  <= wr_idx[1:0];
        trig_word_r <= reg_wdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (timing_rst) begin
      trigger_completed_flag_r <= 1'b0;
    end else if (trigger_fired && trigger_notify) begin
      trigger_completed_flag_r <= 1'b1;
    end else if (rd_sts) begin
      trigger_completed_flag_r <= 1'b0;
    end
  end

  assign tx_stamp_ready    = tx_stamp_pending && !clock_reset_bit_r;
  assign rx_stamp_ready    = rx_stamp_pending && !clock_reset_bit_r;
  assign event_stamp_ready = event_stamp_pending && !clock_reset_bit_r;

  // enables only; other bits ignore writes
  always_ff @(posedge mclk) begin
    if (timing_rst) begin
      irq_en_r <= ptc_pkg::IE_RESET;
    end else if (wr_sts) begin
      irq_en_r <= reg_wdata[ptc_pkg::STS_TX_IE:ptc_pkg::STS_EVENT_STAMP_IRQ_EN];
    end
  end

  assign flags = {tx_stamp_ready, rx_stamp_ready, trigger_completed_flag_r, event_stamp_ready};

  assign rd_value = (rd_src_r == ptc_pkg::PTC_SRC_CLOCK) ? sample_r :
                    (rd_src_r == ptc_pkg::PTC_SRC_TRIG)  ? trigger_info : ptc_pkg::TIME_RESET;

  // read data mux
  always_comb begin
    rdata_nxt = ptc_pkg::WORD_RESET;
    if (reg_addr == ptc_pkg::PAGE_SEL_ADDR) begin
      rdata_nxt = {13'h0000, register_page_select_r};
    end else if (page_ok) begin
      unique case (reg_addr)
        ptc_pkg::CTL_ADDR: begin
          rdata_nxt[ptc_pkg::CTL_CLK_RESET] = clock_reset_bit_r;
          rdata_nxt[ptc_pkg::CTL_CLK_RUN]   = tif.running;
        end
        ptc_pkg::TDR_ADDR: begin
          if (!rd_done) begin
            rdata_nxt = rd_value[16 * rd_idx[1:0] +: 16];
          end
        end
        ptc_pkg::STS_ADDR: begin
          rdata_nxt[ptc_pkg::STS_TX_RDY:ptc_pkg::STS_EVENT_RDY] = flags;
          rdata_nxt[ptc_pkg::STS_TX_IE:ptc_pkg::STS_EVENT_STAMP_IRQ_EN]   = irq_en_r;
        end
        default: begin
          rdata_nxt = ptc_pkg::WORD_RESET;
        end
      endcase
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata_r  <= ptc_pkg::WORD_RESET;
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd) begin
        reg_rdata_r <= rdata_nxt;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (timing_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(flags & irq_en_r);
    end
  end

  // registered copies of clock state
  always_ff @(posedge mclk) begin
    if (rst) begin
      clock_running_r <= 1'b0;
      clock_time_r    <= ptc_pkg::TIME_RESET;
      timing_reset_r  <= 1'b0;
    end else begin
      clock_running_r <= tif.running;
      clock_time_r    <= tif.now;
      timing_reset_r  <= clock_reset_bit_r;
    end
  end

  assign reg_rdata           = reg_rdata_r;
  assign reg_rvalid          = reg_rvalid_r;
  assign irq                 = irq_r;
  assign trigger_word_valid  = trig_valid_r;
  assign trigger_word_idx    = trig_idx_r;
  assign trigger_word        = trig_word_r;
  assign clock_running       = clock_running_r;
  assign clock_time          = clock_time_r;
  assign timing_reset_active = timing_reset_r;
endmodule : ptc_clock_regs

/* File: tb/ptc_clock_regs_asserts.sv */
// assertion checker for the timing clock register block
`timescale 1ns/100ps
module ptc_clock_regs_asserts (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        tx_stamp_pending,
  input wire logic        rx_stamp_pending,
  input wire logic        event_stamp_pending,
  input wire logic        trigger_word_valid,
  input wire logic        timing_reset_active,
  input wire logic        clock_running,
  input wire logic [63:0] clock_time,
  input wire logic        irq
);
  logic [2:0] page_r;
  logic       sel, wr_ctl, rd_ctl, rd_sts, rd_bad;
  // shadow of the page select, only to qualify accesses
  always_ff @(posedge mclk) begin
    if (rst) begin
      page_r <= 3'h0;
    end else if (reg_wr && reg_addr == ptc_pkg::PAGE_SEL_ADDR) begin
      page_r <= reg_wdata[2:0];
    end
  end
  assign sel    = page_r == ptc_pkg::PAGE_TIMING;
  assign wr_ctl = reg_wr && sel && reg_addr == ptc_pkg::CTL_ADDR;
  assign rd_ctl = reg_rd && sel && reg_addr == ptc_pkg::CTL_ADDR;
  assign rd_sts = reg_rd && sel && reg_addr == ptc_pkg::STS_ADDR;
  assign rd_bad = reg_rd && reg_addr != ptc_pkg::PAGE_SEL_ADDR &&
                  !(sel && reg_addr inside {ptc_pkg::CTL_ADDR, ptc_pkg::TDR_ADDR, ptc_pkg::STS_ADDR});
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_ctl_rd; rd_ctl ##1 reg_rvalid; endsequence
  sequence s_sts_rd; rd_sts ##1 reg_rvalid; endsequence
  sequence s_clk_rst; timing_reset_active [*3]; endsequence
  AST_RVALID_AFTER_RD: assert property (reg_rd |=> reg_rvalid)
    else $error("no read answer one cycle after read strobe");
  AST_NO_STRAY_RVALID: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read answer without read strobe");
  AST_RDATA_HOLDS: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved between reads");
  AST_REFUSED_READ_ZERO: assert property (rd_bad |=> reg_rdata == 16'h0000)
    else $error("unmapped or wrong page read not zero");
  AST_CTL_SELF_CLEAR: assert property (s_ctl_rd |-> reg_rdata[15:3] == 13'h0000 && !reg_rdata[1])
    else $error("command bits read back nonzero");
  AST_STS_RESERVED: assert property (s_sts_rd |-> reg_rdata[15:12] == 4'h0 && reg_rdata[7:4] == 4'h0)
    else $error("status reserved bits nonzero");
  AST_READY_LIVE: assert property (s_sts_rd |-> (!reg_rdata[11] || $past(tx_stamp_pending)) &&
    (!reg_rdata[10] || $past(rx_stamp_pending)) && (!reg_rdata[8] || $past(event_stamp_pending)))
    else $error("ready flag without pending stamp");
  AST_RUN_STARTS: assert property (wr_ctl && reg_wdata[2:0] == 3'h4 |-> ##2 clock_running)
    else $error("run write did not start clock");
  AST_HALT_STOPS: assert property (wr_ctl && reg_wdata[1] |-> ##2 !clock_running)
    else $error("halt write did not stop clock");
  AST_CLK_RESET_HOLDS: assert property (s_clk_rst |-> clock_time == 64'h0 && !clock_running && !irq)
    else $error("clock logic not held in reset");
  AST_TRIG_WORD_CAUSE: assert property (trigger_word_valid |-> $past(reg_wr) && $past(reg_addr) == 5'h15)
    else $error("trigger word without data port write");
endmodule : ptc_clock_regs_asserts

bind ptc_clock_regs ptc_clock_regs_asserts u_asserts (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .tx_stamp_pending(tx_stamp_pending), .rx_stamp_pending(rx_stamp_pending),
  .event_stamp_pending(event_stamp_pending), .trigger_word_valid(trigger_word_valid),
  .timing_reset_active(timing_reset_active), .clock_running(clock_running), .clock_time(clock_time), .irq(irq));

/* File: tb/ptc_host_model.sv */
// management host model driving the register strobes
`timescale 1ns/100ps
module ptc_host_model (
  input  wire logic        mclk,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [4:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 5'h00;
    reg_wdata = 16'h0000;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr    = 1'b0;
    // released data must not look valid
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge mclk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd   = 1'b0;
    d        = (reg_rvalid === 1'b1) ? reg_rdata : 16'hXXXX;
  endtask : rd
  task automatic sel_page();
    wr(ptc_pkg::PAGE_SEL_ADDR, 16'h0004);
  endtask : sel_page
endmodule : ptc_host_model

/* File: tb/ptc_clock_regs_tb_top.sv */
// self-checking bench for the timing clock register block
`timescale 1ns/100ps
module ptc_clock_regs_tb_top;
  logic        mclk, rst, reg_wr, reg_rd, reg_rvalid, irq;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, trigger_word, w;
  logic        tx_stamp_pending, rx_stamp_pending, event_stamp_pending, trigger_fired, trigger_notify;
  logic        trigger_word_valid, timing_reset_active, clock_running;
  logic [1:0]  trigger_word_idx;
  logic [63:0] trigger_info, clock_time, t, d;
  int          fails, checked, seed, cyc, i;
  localparam logic [4:0] CTL = ptc_pkg::CTL_ADDR;
  localparam logic [4:0] TDR = ptc_pkg::TDR_ADDR;
  localparam logic [4:0] STS = ptc_pkg::STS_ADDR;

  ptc_clock_regs dut (.mclk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .tx_stamp_pending, .rx_stamp_pending, .event_stamp_pending, .trigger_fired, .trigger_notify, .trigger_info,
    .trigger_word_valid, .trigger_word_idx, .trigger_word, .timing_reset_active, .clock_running, .clock_time, .irq);
  ptc_host_model host (.mclk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [63:0] tadd(input logic [63:0] a, input logic [63:0] b);
    logic [32:0] ns;
    ns = {1'b0, a[31:0]} + {1'b0, b[31:0]};
    if (ns >= 33'h0_3B9A_CA00) ns = ns - 33'h0_3B9A_CA00;
    return {a[63:32] + b[63:32] + 32'((a[31:0] + b[31:0]) != ns[31:0]), ns[31:0]};
  endfunction : tadd
  function automatic logic [15:0] sts(input logic [3:0] flags, input logic [3:0] ie);
    return {4'h0, flags, 4'h0, ie};
  endfunction : sts
  function automatic logic [63:0] rnd_time();
    return {32'($random(seed)), 32'(unsigned'($random(seed)) % 32'h3B9A_CA00)};
  endfunction : rnd_time

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp, input string name);
    logic [15:0] v;
    host.rd(a, v);
    chk(name, 64'(v), 64'(exp));
  endtask : rdchk
  task automatic put_time(input logic [63:0] v, input logic [15:0] cmd);
    for (int k = 0; k < 4; k++) host.wr(TDR, v[16*k+:16]);
    host.wr(CTL, cmd);
  endtask : put_time
  task automatic read_words(input logic [63:0] v, input logic [15:0] cmd);
    host.wr(CTL, cmd);
    for (int k = 0; k < 4; k++) rdchk(TDR, v[16*k+:16], "data_word");
    rdchk(TDR, 16'h0000, "past_last_word");
  endtask : read_words
  task automatic finish_test();
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    seed = 32'h471a;
    {rst, tx_stamp_pending, rx_stamp_pending, event_stamp_pending, trigger_fired, trigger_notify} = 6'h20;
    trigger_info = 64'h0;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    rdchk(STS, 16'h0000, "sts_without_page");
    host.wr(5'h1F, 16'hFFFF);
    rdchk(5'h1F, 16'h0000, "unmapped");
    host.sel_page();
    rdchk(TDR, 16'h0000, "tdr_no_source");
    rdchk(STS, 16'h0000, "sts_reset");
    for (i = 0; i < 8; i++) begin
      w = (i == 0) ? 16'hFFFF : 16'($random(seed));
      {tx_stamp_pending, rx_stamp_pending, event_stamp_pending} = (i == 0) ? 3'h7 : 3'($random(seed));
      host.wr(STS, w);
      rdchk(STS, sts({tx_stamp_pending, rx_stamp_pending, 1'b0, event_stamp_pending}, w[3:0]), "status");
      chk("irq", irq, |({tx_stamp_pending, rx_stamp_pending, 1'b0, event_stamp_pending} & w[3:0]));
    end
    {tx_stamp_pending, rx_stamp_pending, event_stamp_pending} = 3'h0;
    host.wr(STS, 16'h0002);
    trigger_fired = 1'b1;
    @(negedge mclk);
    trigger_fired = 1'b0;
    rdchk(STS, sts(4'h0, 4'h2), "trig_not_notified");
    {trigger_fired, trigger_notify} = 2'h3;
    @(negedge mclk);
    trigger_fired = 1'b0;
    @(negedge mclk);
    chk("irq_trig", irq, 1'b1);
    rdchk(STS, sts(4'h2, 4'h2), "trigger_completed_flag");
    rdchk(STS, sts(4'h0, 4'h2), "trig_cleared");
    for (i = 0; i < 4; i++) begin
      t = (i == 0) ? {32'hFFFF_FFFE, 32'd999_999_990} : rnd_time();
      d = (i == 0) ? {32'h0000_0001, 32'd20} : rnd_time();
      put_time(t, 16'h0010);
      rdchk(CTL, 16'h0000, "ctl_after_load");
      read_words(t, 16'h0020);
      put_time(d, 16'h0008);
      read_words(tadd(t, d), 16'h0020);
    end
    put_time({32'h0000_0007, 32'd999_999_900}, 16'h0010);
    host.wr(CTL, 16'h0004);
    rdchk(CTL, 16'h0004, "ctl_running");
    chk("running_out", clock_running, 1'b1);
    host.wr(CTL, 16'h0000);
    rdchk(CTL, 16'h0004, "zero_keeps_run");
    t = clock_time;
    repeat (8) begin
      @(negedge mclk);
      t = tadd(t, 64'd10);
      chk("tick", clock_time, t);
    end
    host.wr(CTL, 16'h0002);
    rdchk(CTL, 16'h0000, "ctl_halted");
    t = clock_time;
    repeat (3) @(negedge mclk);
    chk("time_frozen", clock_time, t);
    chk("halted_out", clock_running, 1'b0);
    host.wr(STS, 16'h000F);
    host.wr(CTL, 16'h0005);
    rdchk(CTL, 16'h0001, "reset_held");
    repeat (4) @(negedge mclk);
    chk("time_in_reset", clock_time, 64'h0);
    chk("reset_active", timing_reset_active, 1'b1);
    rdchk(STS, 16'h0000, "sts_in_reset");
    host.wr(CTL, 16'h0000);
    rdchk(CTL, 16'h0000, "reset_released");
    chk("reset_inactive", timing_reset_active, 1'b0);
    rdchk(STS, 16'h0000, "ie_cleared");
    rdchk(TDR, 16'h0000, "tdr_cleared");
    trigger_info = {32'($random(seed)), 32'($random(seed))};
    d = rnd_time();
    host.wr(CTL, 16'h0040);
    for (i = 0; i < 4; i++) begin
      host.wr(TDR, d[16*i+:16]);
      chk("trig_word", {trigger_word_valid, trigger_word_idx, trigger_word}, {1'b1, 2'(i), d[16*i+:16]});
    end
    read_words(trigger_info, 16'h0080);
    finish_test();
  end
endmodule : ptc_clock_regs_tb_top
